// ---- hw/sim_monitor.v ----
// Serial register slave with results of steps 14 and 15 and the monitor configuration.
// Assumes serial pins are asynchronous to mclk_i and that sclk is far slower than mclk_i.
`timescale 1ns/1ps
`include "sim_map.vh"

module sim_monitor #(
    parameter TIMEOUT_OSC = `SIM_TIMEOUT_OSC,
    parameter WIN1_OSC    = `SIM_WIN1_OSC,
    parameter WIN2_OSC    = `SIM_WIN2_OSC,
    parameter WIN3_OSC    = `SIM_WIN3_OSC,
    parameter FAULT_BITS  = 8
) (
    input  wire                  mclk_i,
    input  wire                  nrst_i,
    input  wire                  csn_i,
    input  wire                  sclk_i,
    input  wire                  sdi_i,
    input  wire [15:0]           adc_b_step_fourteen_result_i,
    input  wire [15:0]           adc_b_step_fifteen_result_i,
    input  wire [FAULT_BITS-1:0] fault_status_i,
    input  wire [FAULT_BITS-1:0] fault_mask_i,
    output reg                   sdo_o,
    output reg                   sdo_oe_o,
    output reg                   fault_o,
    output reg                   host_loss_o,
    output reg                   map_section_one_check_enable_o,
    output reg                   crc_type_o,
    output reg  [15:0]           sclk_count_o,
    output reg                   frame_timeout_o
);

    // ----------------------------------------
    // Oscillator-period enable, rounded up so periods are never shorter
    // ----------------------------------------
    localparam integer OSC_DIV_N =
        (`SIM_OSC_PERIOD_PS + `SIM_MCLK_PERIOD_PS - 1) / `SIM_MCLK_PERIOD_PS;
    localparam [7:0]   OSC_DIV   = OSC_DIV_N[7:0];
    reg [7:0]  osc_cnt;
    reg        osc_tick;
    always @(posedge mclk_i) begin
        if (!nrst_i) begin
            osc_cnt  <= 8'h00;
            osc_tick <= 1'b0;
        end else begin
            osc_tick <= (osc_cnt == OSC_DIV - 8'h01);
            osc_cnt  <= (osc_cnt == OSC_DIV - 8'h01) ? 8'h00 : osc_cnt + 8'h01;
        end
    end

    // ----------------------------------------
    // Pin synchronisers and edge detection
    // ----------------------------------------
    reg [1:0] csn_s, sclk_s, sdi_s;
    reg       csn_d, sclk_d;
    always @(posedge mclk_i) begin
        if (!nrst_i) begin
            csn_s  <= 2'b11;
            sclk_s <= 2'b00;
            sdi_s  <= 2'b00;
            csn_d  <= 1'b1;
            sclk_d <= 1'b0;
        end else begin
            csn_s  <= {csn_s[0], csn_i};
            sclk_s <= {sclk_s[0], sclk_i};
            sdi_s  <= {sdi_s[0], sdi_i};
            csn_d  <= csn_s[1];
            sclk_d <= sclk_s[1];
        end
    end
    wire cs_fall = csn_d & ~csn_s[1];
    wire cs_rise = ~csn_d & csn_s[1];
    wire sck_up  = ~sclk_d & sclk_s[1] & ~csn_s[1];
    wire sck_dn  = sclk_d & ~sclk_s[1] & ~csn_s[1];

    // ----------------------------------------
    // Registers and frame state
    // ----------------------------------------
    reg  [15:0] cfg;
    reg  [15:0] step14, step15;
    reg  [5:0]  bit_cnt;
    reg  [23:0] payload;
    reg  [15:0] rx_crc, crc, out_sh;
    reg  [14:0] to_cnt;
    reg         timed_out, in_frame;
    wire [15:0] poly = cfg[`SIM_CFG_CRC_TYPE] ? `SIM_POLY_ANSI : `SIM_POLY_CCITT;
    wire        fb   = crc[15] ^ sdi_s[1];
    wire [15:0] next_crc = {crc[14:0], 1'b0} ^ (fb ? poly : 16'h0000);
    wire [6:0]  addr = payload[22:16];
    wire        frame_ok = in_frame && !timed_out && bit_cnt == `SIM_FRAME_BITS
                           && rx_crc == crc;
    reg  [15:0] rd_data;

    always @* begin
        case (payload[6:0])
            `SIM_ADDR_STEP14: rd_data = step14;
            `SIM_ADDR_STEP15: rd_data = step15;
            `SIM_ADDR_CFG:    rd_data = cfg;
            default:          rd_data = 16'h0000;
        endcase
    end

    // Results track the sequencer; bus writes never reach them
    always @(posedge mclk_i) begin
        if (!nrst_i) begin
            step14 <= `SIM_RESULT_RESET;
            step15 <= `SIM_RESULT_RESET;
        end else begin
            step14 <= adc_b_step_fourteen_result_i;
            step15 <= adc_b_step_fifteen_result_i;
        end
    end

    always @(posedge mclk_i) begin
        if (!nrst_i) begin
            cfg       <= `SIM_CFG_RESET;
            bit_cnt   <= 6'd0;
            payload   <= 24'h000000;
            rx_crc    <= 16'h0000;
            crc       <= `SIM_CRC_INIT;
            out_sh    <= 16'h0000;
            to_cnt    <= 15'd0;
            timed_out <= 1'b0;
            in_frame  <= 1'b0;
        end else if (cs_fall) begin
            // Only a falling chip-select opens a frame, so a stuck one stays dead
            in_frame  <= 1'b1;
            timed_out <= 1'b0;
            bit_cnt   <= 6'd0;
            crc       <= `SIM_CRC_INIT;
            to_cnt    <= 15'd0;
            out_sh    <= 16'h0000;
        end else if (cs_rise) begin
            in_frame <= 1'b0;
            if (frame_ok && payload[23] && addr == `SIM_ADDR_CFG)
                cfg <= payload[15:0] & `SIM_CFG_WMASK;
        end else if (in_frame) begin
            if (cfg[`SIM_CFG_TIMEOUT_EN] && osc_tick && !timed_out) begin
                if (to_cnt == TIMEOUT_OSC - 1)
                    timed_out <= 1'b1;
                to_cnt <= to_cnt + 15'd1;
            end
            if (sck_up && !timed_out && bit_cnt != `SIM_FRAME_BITS) begin
                bit_cnt <= bit_cnt + 6'd1;
                if (bit_cnt < `SIM_PAYLOAD_BITS) begin
                    payload <= {payload[22:0], sdi_s[1]};
                    crc     <= next_crc;
                end else begin
                    rx_crc <= {rx_crc[14:0], sdi_s[1]};
                end
            end
            // Read data is loaded once the command byte is in, then shifted on falling edges
            if (sck_dn && bit_cnt == `SIM_CMD_BITS)
                out_sh <= rd_data;
            else if (sck_dn && bit_cnt > `SIM_CMD_BITS && bit_cnt < `SIM_PAYLOAD_BITS)
                out_sh <= {out_sh[14:0], 1'b0};
        end
    end

    // ----------------------------------------
    // Host-loss watchdog
    // ----------------------------------------
    reg  [14:0] wd_cnt;
    reg         host_lost;
    wire [14:0] wd_lim = (cfg[1:0] == 2'b01) ? WIN1_OSC[14:0] :
                         (cfg[1:0] == 2'b10) ? WIN2_OSC[14:0] : WIN3_OSC[14:0];
    wire        valid_cmd = cs_rise && frame_ok;
    always @(posedge mclk_i) begin
        if (!nrst_i) begin
            wd_cnt    <= 15'd0;
            host_lost <= 1'b0;
        end else if (cfg[`SIM_CFG_WIN_HI:`SIM_CFG_WIN_LO] == 2'b00) begin
            wd_cnt    <= 15'd0;
            host_lost <= 1'b0;
        end else if (valid_cmd) begin
            wd_cnt <= 15'd0;
        end else if (osc_tick && !host_lost) begin
            if (wd_cnt >= wd_lim - 15'd1)
                host_lost <= 1'b1;
            wd_cnt <= wd_cnt + 15'd1;
        end
    end

    // ----------------------------------------
    // Clock edge counter and outputs
    // ----------------------------------------
    // Counter wraps silently; software reads it as a rolling total
    always @(posedge mclk_i) begin
        if (!nrst_i) begin
            sclk_count_o <= 16'h0000;
        end else if (!cfg[`SIM_CFG_SCLK_CNT_EN]) begin
            sclk_count_o <= 16'h0000;
        end else if (sck_up) begin
            sclk_count_o <= sclk_count_o + 16'h0001;
        end
    end

    always @(posedge mclk_i) begin
        if (!nrst_i) begin
            sdo_o                          <= 1'b0;
            sdo_oe_o                       <= 1'b0;
            fault_o                        <= 1'b0;
            host_loss_o                    <= 1'b0;
            map_section_one_check_enable_o <= 1'b0;
            crc_type_o                     <= 1'b0;
            frame_timeout_o                <= 1'b0;
        end else begin
            sdo_o    <= in_frame & out_sh[15];
            sdo_oe_o <= in_frame;
            fault_o  <= ~(|(fault_status_i & ~fault_mask_i))
                        ^ cfg[`SIM_CFG_FAULT_OUTPUT_POLARITY];
            host_loss_o <= ~host_lost ^ cfg[`SIM_CFG_HOST_POL];
            map_section_one_check_enable_o <= cfg[`SIM_CFG_MAP_CRC_EN];
            crc_type_o      <= cfg[`SIM_CFG_CRC_TYPE];
            frame_timeout_o <= timed_out;
        end
    end

endmodule // sim_monitor

// ---- common/sim_map.vh ----
// Offsets, field positions, reset values and timing counts of the integrity monitor block.
// Assumes a 16-bit register map that the host reaches over the serial port.
`ifndef SIM_MAP_VH
`define SIM_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SIM_ADDR_STEP14      7'h2E
`define SIM_ADDR_STEP15      7'h2F
`define SIM_ADDR_CFG         7'h40

// ----------------------------------------
// Configuration fields
// ----------------------------------------
`define SIM_CFG_MAP_CRC_EN   15
`define SIM_CFG_CRC_TYPE     14
`define SIM_CFG_SCLK_CNT_EN  13
`define SIM_CFG_TIMEOUT_EN   12
`define SIM_CFG_FAULT_OUTPUT_POLARITY    8
`define SIM_CFG_HOST_POL     2
`define SIM_CFG_WIN_HI       1
`define SIM_CFG_WIN_LO       0
`define SIM_CFG_WMASK        16'hF107
`define SIM_CFG_RESET        16'h0000
`define SIM_RESULT_RESET     16'h0000

// ----------------------------------------
// Frame layout and check polynomials
// ----------------------------------------
`define SIM_FRAME_BITS       6'd40
`define SIM_CMD_BITS         6'd8
`define SIM_PAYLOAD_BITS     6'd24
`define SIM_CRC_INIT         16'hFFFF
`define SIM_POLY_CCITT       16'h1021
`define SIM_POLY_ANSI        16'h8005

// ----------------------------------------
// Timing, in oscillator periods; oscillator and mclk periods in picoseconds
// ----------------------------------------
`define SIM_TIMEOUT_OSC      16384
`define SIM_WIN1_OSC         5120
`define SIM_WIN2_OSC         10240
`define SIM_WIN3_OSC         20480
`define SIM_OSC_PERIOD_PS    122070
`define SIM_MCLK_PERIOD_PS   20000

`endif

// ---- verification/sim_monitor_props.sv ----
// Checker for the integrity monitor: serial frame, fault and timeout outputs.
// Assumes a bind onto sim_monitor and a host that keeps sclk low between frames.
`timescale 1ns/1ps
module sim_monitor_props #(
    parameter FAULT_BITS = 8
) (
    input wire logic                  mclk_i,
    input wire logic                  nrst_i,
    input wire logic                  csn_i,
    input wire logic                  sclk_i,
    input wire logic [FAULT_BITS-1:0] fault_status_i,
    input wire logic [FAULT_BITS-1:0] fault_mask_i,
    input wire logic                  sdo_o,
    input wire logic                  sdo_oe_o,
    input wire logic                  fault_o,
    input wire logic                  map_section_one_check_enable_o,
    input wire logic                  crc_type_o,
    input wire logic [15:0]           sclk_count_o,
    input wire logic                  frame_timeout_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    // Six samples cover the two-stage pin synchroniser
    sequence s_cs_high; csn_i [*6]; endsequence
    sequence s_cs_low;  !csn_i [*6]; endsequence
    a_oe_closed: assert property (s_cs_high |-> !sdo_oe_o)
        else $error("output enable left high");
    a_oe_open: assert property (s_cs_low |-> sdo_oe_o || frame_timeout_o)
        else $error("output enable low in frame");
    a_sdo_idle: assert property (!sdo_oe_o [*2] |-> !sdo_o)
        else $error("sdo not released");
    a_count_still: assert property ($stable(sclk_i) [*8] |-> $stable(sclk_count_o)
        || sclk_count_o == 16'h0000)
        else $error("count moved without sclk");
    a_count_step: assert property ($changed(sclk_count_o) |->
        sclk_count_o == $past(sclk_count_o) + 16'h0001 || sclk_count_o == 16'h0000)
        else $error("count jumped");
    a_fault_tracks: assert property ($changed(|(fault_status_i & ~fault_mask_i))
        |-> ##[1:2] $changed(fault_o))
        else $error("fault output missed change");
    a_timeout_hold: assert property (frame_timeout_o && csn_i |=> frame_timeout_o)
        else $error("timeout flag cleared early");
    a_timeout_late: assert property ($rose(frame_timeout_o) |->
        sdo_oe_o && $past(sdo_oe_o, 100))
        else $error("timeout without long frame");
    a_cfg_between: assert property ($changed({crc_type_o, map_section_one_check_enable_o})
        |-> !sdo_oe_o)
        else $error("config changed inside frame");
endmodule // sim_monitor_props
bind sim_monitor sim_monitor_props #(.FAULT_BITS(FAULT_BITS)) u_props (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .csn_i(csn_i), .sclk_i(sclk_i),
    .fault_status_i(fault_status_i), .fault_mask_i(fault_mask_i),
    .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .fault_o(fault_o),
    .map_section_one_check_enable_o(map_section_one_check_enable_o),
    .crc_type_o(crc_type_o), .sclk_count_o(sclk_count_o),
    .frame_timeout_o(frame_timeout_o));

// ---- verification/sim_host.sv ----
// Host controller model: mode 0 serial frames of 40 bits with a 16-bit check.
// Assumes the bench calls xfer and waits for it to return.
`timescale 1ns/1ps
module sim_host (
    output logic      csn_o,
    output logic      sclk_o,
    output logic      sdi_o,
    input  wire logic sdo_i
);
    initial begin
        csn_o = 1'b1;
        sclk_o = 1'b0;
        sdi_o = 1'b0;
    end
    function automatic logic [15:0] crc24(input logic [23:0] d, input logic ansi);
        logic [15:0] c;
        c = 16'hFFFF;
        for (int i = 23; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? (ansi ? 16'h8005 : 16'h1021) : 16'h0000);
        return c;
    endfunction
    // Stall holds sclk high on frame bit 19 (the 21st sent), long enough to trip the frame timeout
    task automatic xfer(input logic w, input logic [6:0] a, input logic [15:0] d,
                        input logic ansi, input int stall, output logic [15:0] rd);
        logic [39:0] f;
        f = {w, a, d, crc24({w, a, d}, ansi)};
        rd = 16'h0000;
        csn_o = 1'b0;
        #80;
        for (int i = 39; i >= 0; i--) begin
            sdi_o = f[i];
            #80 sclk_o = 1'b1;
            if (i == 19)
                #(stall);
            #78;
            if (i <= 31 && i >= 16)
                rd = {rd[14:0], sdo_i};
            #2 sclk_o = 1'b0;
        end
        #80 csn_o = 1'b1;
        sdi_o = ~sdi_o;
        #200;
    endtask
endmodule // sim_host

// ---- verification/sim_monitor_tb.sv ----
// Bench for the integrity monitor: register reads and writes over the host model.
// Assumes short timeout and watchdog parameters so that the run stays brief.
`timescale 1ns/1ps
`include "sim_map.vh"
module sim_monitor_tb;
    logic        mclk, nrst;
    logic [7:0]  fst, fmsk;
    logic [15:0] rd, c0, s14, s15;
    wire         csn, sclk, sdi, sdo, fault, loss, map_en, ctype, tmo;
    wire  [15:0] cnt;
    int          errors, total_checks;
    sim_host host (.csn_o(csn), .sclk_o(sclk), .sdi_o(sdi), .sdo_i(sdo));
    sim_monitor #(.TIMEOUT_OSC(64), .WIN1_OSC(40), .WIN2_OSC(80), .WIN3_OSC(160)) dut (
        .mclk_i(mclk), .nrst_i(nrst), .csn_i(csn), .sclk_i(sclk), .sdi_i(sdi),
        .adc_b_step_fourteen_result_i(s14), .adc_b_step_fifteen_result_i(s15),
        .fault_status_i(fst), .fault_mask_i(fmsk), .sdo_o(sdo), .sdo_oe_o(),
        .fault_o(fault), .host_loss_o(loss), .map_section_one_check_enable_o(map_en),
        .crc_type_o(ctype), .sclk_count_o(cnt), .frame_timeout_o(tmo));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #400000;
        errors++;
        summarize();
    end
    initial begin
        nrst = 1'b0;
        fst = 8'h00;
        fmsk = 8'h00;
        s14 = 16'h8001;
        s15 = 16'h7FFE;
        step(8);
        nrst = 1'b1;
        step(4);
        check("fault", fault, 16'h0001);
        check("count", cnt, 16'h0000);
        host.xfer(0, `SIM_ADDR_STEP14, 0, 0, 0, rd);
        check("step14", rd, 16'h8001);
        host.xfer(0, `SIM_ADDR_STEP15, 0, 0, 0, rd);
        check("step15", rd, 16'h7FFE);
        // Result must follow the sequencer, never the bus
        s14 = 16'h4321;
        host.xfer(1, `SIM_ADDR_STEP14, 16'hFFFF, 0, 0, rd);
        host.xfer(0, `SIM_ADDR_STEP14, 0, 0, 0, rd);
        check("step14 ro", rd, 16'h4321);
        host.xfer(1, `SIM_ADDR_CFG, 16'hFFFF, 0, 0, rd);
        check("type", ctype, 16'h0001);
        check("map", map_en, 16'h0001);
        c0 = cnt;
        host.xfer(0, `SIM_ADDR_CFG, 0, 1, 0, rd);
        check("cfg", rd, 16'hF107);
        check("count", cnt, c0 + 16'h0028);
        fst = 8'h01;
        step(3);
        check("fault hi", fault, 16'h0001);
        fmsk = 8'h01;
        step(3);
        check("fault masked", fault, 16'h0000);
        check("loss", loss, 16'h0000);
        step(1300);
        check("loss", loss, 16'h0001);
        host.xfer(1, `SIM_ADDR_CFG, 16'h1004, 1, 0, rd);
        check("loss clr", loss, 16'h0000);
        check("fault lo", fault, 16'h0001);
        check("type", ctype, 16'h0000);
        host.xfer(1, `SIM_ADDR_CFG, 16'h4000, 0, 12000, rd);
        check("tmo", tmo, 16'h0001);
        host.xfer(0, `SIM_ADDR_CFG, 0, 0, 0, rd);
        check("cfg kept", rd, 16'h1004);
        check("tmo clr", tmo, 16'h0000);
        check("count off", cnt, 16'h0000);
        // Shortest window first; a wider window alone must not clear the flag
        host.xfer(1, `SIM_ADDR_CFG, 16'h0005, 0, 0, rd);
        step(200);
        check("loss win1 early", loss, 16'h0000);
        step(100);
        check("loss win1", loss, 16'h0001);
        host.xfer(1, `SIM_ADDR_CFG, 16'h0006, 0, 0, rd);
        check("loss sticky", loss, 16'h0001);
        host.xfer(1, `SIM_ADDR_CFG, 16'h0004, 0, 0, rd);
        check("loss off", loss, 16'h0000);
        host.xfer(1, `SIM_ADDR_CFG, 16'h0006, 0, 0, rd);
        step(500);
        check("loss win2 early", loss, 16'h0000);
        step(100);
        check("loss win2", loss, 16'h0001);
        summarize();
    end
endmodule // sim_monitor_tb
